/* File: core/agc_defines.svh */
// Purpose: Constants for the converter calibration correction block.
// Assumes: Byte-wide register port, 200 MHz reference clock.
// Notes: Offsets are byte addresses of the register port.
`ifndef AGC_DEFINES_SVH
`define AGC_DEFINES_SVH
`define AGC_ADDR_MOFS_LO 8'h07
`define AGC_ADDR_MOFS_MD 8'h08
`define AGC_ADDR_MOFS_HI 8'h09
`define AGC_ADDR_MGAIN_LO 8'h0a
`define AGC_ADDR_MGAIN_MD 8'h0b
`define AGC_ADDR_MGAIN_HI 8'h0c
`define AGC_ADDR_AOFS_LO 8'h17
`define AGC_ADDR_AOFS_HI 8'h18
`define AGC_ADDR_AGAIN_LO 8'h19
`define AGC_ADDR_AGAIN_HI 8'h1a
`define AGC_ADDR_CTRL 8'h20
`define AGC_ADDR_STATUS 8'h21
`define AGC_MOFS_RST 24'h00_0000
`define AGC_MGAIN_RST 24'h40_0000
`define AGC_AOFS_RST 16'h0000
`define AGC_AGAIN_RST 16'h4000
`define AGC_MGAIN_SHIFT 22
`define AGC_AGAIN_SHIFT 14
`define AGC_CAL_READINGS 5'h10
`define AGC_CAL_LOG2 4
`define AGC_CTRL_CHOP_BIT 0
`define AGC_CTRL_CAL_BIT 1
`endif

/* File: core/agc_pkg.sv */
// Purpose: Types for the converter calibration correction block.
// Assumes: Used together with agc_defines.svh.
// Notes: Nothing here holds a number of the register map.
package agc_pkg;
   typedef enum logic [2:0] {
      AGC_IDLE = 3'b001,
      AGC_ACCUM = 3'b010,
      AGC_STORE = 3'b100
   } agc_state_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } agc_bus_s;
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } agc_sample_s;
endpackage

/* File: core/agc_calibration.sv */
// Purpose: Offset and gain correction of the main and auxiliary filter outputs.
// Assumes: Filter samples arrive as one-cycle valid pulses on ref_clk.
// Notes: Also runs the main offset self-calibration over sixteen readings.
// Functional notes
// - Main coefficients 24 bits, auxiliary 16 bits.
// - Main result: subtract offset, scale gain/400000h.
// - Saturate main result to 32 bits.
// - Main offset is signed two's complement.
// - Main offset shifted up to data MSBs.
// - Zero offset leaves data unchanged.
// - Chop mode disables main offset subtraction.
// - Main offset bytes at 07h to 09h.
// - Auxiliary offset bytes at 17h, 18h.
// - Auxiliary offset aligned to upper result bits.
// - Main gain unsigned, unity at 400000h.
// - Main gain bytes at 0Ah to 0Ch.
// - Auxiliary gain unsigned, unity at 4000h.
// - Auxiliary gain bytes at 19h, 1Ah.
// - Self-calibration shorts inputs, averages sixteen readings.
// - Ready output high during calibration.
// - Main offset coefficient updated, ready low at completion.
`timescale 1ns/100ps
`include "agc_defines.svh"
module agc_calibration (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port
   input wire agc_pkg::agc_bus_s bus_in,
   output logic [7:0] rd_data_ff,
   // Filter outputs
   input wire agc_pkg::agc_sample_s main_sample,
   input wire logic [23:0] aux_sample,
   input wire logic aux_valid,
   // Self-calibration command
   input wire logic main_offset_selfcal_cmd,
   // Corrected outputs
   output agc_pkg::agc_sample_s main_out_ff,
   output logic [23:0] aux_out_ff,
   output logic aux_out_valid_ff,
   // Converter control
   output logic input_amplifier_short_ff,
   output logic conversion_ready_n_ff
);
   logic [23:0] main_offset_coefficient_ff;
   logic [23:0] main_gain_coefficient_ff;
   logic [15:0] aux_offset_coefficient_ff;
   logic [15:0] aux_gain_coefficient_ff;
   logic chop_en_ff;
   agc_pkg::agc_state_e state_ff;
   agc_pkg::agc_state_e nxt_state;
   logic [4:0] cal_count_ff;
   logic signed [35:0] cal_sum_ff;
   logic [31:0] nxt_main;
   logic [23:0] nxt_aux;
   logic cal_start;
   logic [35:0] cal_avg;

   // Clip a signed product down to the output width.
   function automatic logic [31:0] sat32(input logic signed [58:0] v);
      if (v > 59'sh000_0000_7FFF_FFFF) begin
         sat32 = 32'h7FFF_FFFF;
      end else if (v < -59'sh000_0000_8000_0000) begin
         sat32 = 32'h8000_0000;
      end else begin
         sat32 = v[31:0];
      end
   endfunction

   function automatic logic [23:0] sat24(input logic signed [42:0] v);
      if (v > 43'sh000_007F_FFFF) begin
         sat24 = 24'h7F_FFFF;
      end else if (v < -43'sh000_0080_0000) begin
         sat24 = 24'h80_0000;
      end else begin
         sat24 = v[23:0];
      end
   endfunction

   // Main correction; the subtraction is 34 bits so no case can wrap.
   always_comb begin
      logic signed [33:0] diff;
      logic signed [58:0] prod;
      diff = 34'sh0_0000_0000;
      prod = 59'sh000_0000_0000_0000;
      diff = {{2{main_sample.data[31]}}, main_sample.data};
      if (!chop_en_ff) begin
         // Offset sits in bits 31:8 of the data; zero subtracts nothing.
         diff = diff - {{2{main_offset_coefficient_ff[23]}}, main_offset_coefficient_ff, 8'h00};
      end
      // Gain is unsigned, so it is widened with a zero sign bit.
      prod = (59'(diff) * $signed({35'h0, main_gain_coefficient_ff})) >>> `AGC_MGAIN_SHIFT;
      nxt_main = sat32(prod);
   end

   always_comb begin
      logic signed [25:0] adiff;
      logic signed [42:0] aprod;
      adiff = 26'sh000_0000;
      aprod = 43'sh000_0000_0000;
      // Auxiliary offset lines up with bits 23:8.
      adiff = {{2{aux_sample[23]}}, aux_sample} -
              {{2{aux_offset_coefficient_ff[15]}}, aux_offset_coefficient_ff, 8'h00};
      aprod = (43'(adiff) * $signed({27'h0, aux_gain_coefficient_ff})) >>> `AGC_AGAIN_SHIFT;
      nxt_aux = sat24(aprod);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         main_out_ff <= '0;
         aux_out_ff <= 24'h00_0000;
         aux_out_valid_ff <= 1'b0;
      end else begin
         // Shorted-input readings are not passed on as results.
         main_out_ff.valid <= main_sample.valid && state_ff == agc_pkg::AGC_IDLE;
         main_out_ff.data <= nxt_main;
         aux_out_valid_ff <= aux_valid;
         aux_out_ff <= nxt_aux;
      end
   end

   assign cal_start = main_offset_selfcal_cmd && state_ff == agc_pkg::AGC_IDLE;
   // The raw samples are averaged, independent of the current coefficients.
   assign cal_avg = 36'(cal_sum_ff >>> `AGC_CAL_LOG2);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         agc_pkg::AGC_IDLE: begin
            if (cal_start) begin
               nxt_state = agc_pkg::AGC_ACCUM;
            end
         end
         agc_pkg::AGC_ACCUM: begin
            if (main_sample.valid && cal_count_ff == `AGC_CAL_READINGS - 5'h01) begin
               nxt_state = agc_pkg::AGC_STORE;
            end
         end
         agc_pkg::AGC_STORE: begin
            nxt_state = agc_pkg::AGC_IDLE;
         end
         default: begin
            nxt_state = agc_pkg::AGC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= agc_pkg::AGC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cal_count_ff <= 5'h00;
         cal_sum_ff <= 36'sh0_0000_0000;
      end else if (cal_start) begin
         cal_count_ff <= 5'h00;
         cal_sum_ff <= 36'sh0_0000_0000;
      end else if (state_ff == agc_pkg::AGC_ACCUM && main_sample.valid) begin
         cal_count_ff <= cal_count_ff + 5'h01;
         cal_sum_ff <= cal_sum_ff + {{4{main_sample.data[31]}}, main_sample.data};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         input_amplifier_short_ff <= 1'b0;
         conversion_ready_n_ff <= 1'b1;
      end else begin
         input_amplifier_short_ff <= nxt_state == agc_pkg::AGC_ACCUM;
         if (cal_start) begin
            conversion_ready_n_ff <= 1'b1;
         end else if (state_ff == agc_pkg::AGC_STORE) begin
            conversion_ready_n_ff <= 1'b0;
         end else if (state_ff == agc_pkg::AGC_IDLE && main_sample.valid) begin
            conversion_ready_n_ff <= 1'b0;
         end else if (state_ff == agc_pkg::AGC_IDLE && bus_in.rd) begin
            conversion_ready_n_ff <= 1'b1;
         end
      end
   end

   // Coefficient writes; the calibration store wins over a write in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         main_offset_coefficient_ff <= `AGC_MOFS_RST;
         main_gain_coefficient_ff <= `AGC_MGAIN_RST;
         aux_offset_coefficient_ff <= `AGC_AOFS_RST;
         aux_gain_coefficient_ff <= `AGC_AGAIN_RST;
         chop_en_ff <= 1'b0;
      end else if (state_ff == agc_pkg::AGC_STORE) begin
         main_offset_coefficient_ff <= cal_avg[31:8];
      end else if (bus_in.wr) begin
         if (bus_in.addr == `AGC_ADDR_MOFS_LO) begin
            main_offset_coefficient_ff[7:0] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_MOFS_MD) begin
            main_offset_coefficient_ff[15:8] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_MOFS_HI) begin
            main_offset_coefficient_ff[23:16] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_MGAIN_LO) begin
            main_gain_coefficient_ff[7:0] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_MGAIN_MD) begin
            main_gain_coefficient_ff[15:8] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_MGAIN_HI) begin
            main_gain_coefficient_ff[23:16] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_AOFS_LO) begin
            aux_offset_coefficient_ff[7:0] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_AOFS_HI) begin
            aux_offset_coefficient_ff[15:8] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_AGAIN_LO) begin
            aux_gain_coefficient_ff[7:0] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_AGAIN_HI) begin
            aux_gain_coefficient_ff[15:8] <= bus_in.wdata;
         end else if (bus_in.addr == `AGC_ADDR_CTRL) begin
            chop_en_ff <= bus_in.wdata[`AGC_CTRL_CHOP_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rd_data_ff <= 8'h00;
      end else if (bus_in.rd) begin
         if (bus_in.addr == `AGC_ADDR_MOFS_LO) begin
            rd_data_ff <= main_offset_coefficient_ff[7:0];
         end else if (bus_in.addr == `AGC_ADDR_MOFS_MD) begin
            rd_data_ff <= main_offset_coefficient_ff[15:8];
         end else if (bus_in.addr == `AGC_ADDR_MOFS_HI) begin
            rd_data_ff <= main_offset_coefficient_ff[23:16];
         end else if (bus_in.addr == `AGC_ADDR_MGAIN_LO) begin
            rd_data_ff <= main_gain_coefficient_ff[7:0];
         end else if (bus_in.addr == `AGC_ADDR_MGAIN_MD) begin
            rd_data_ff <= main_gain_coefficient_ff[15:8];
         end else if (bus_in.addr == `AGC_ADDR_MGAIN_HI) begin
            rd_data_ff <= main_gain_coefficient_ff[23:16];
         end else if (bus_in.addr == `AGC_ADDR_AOFS_LO) begin
            rd_data_ff <= aux_offset_coefficient_ff[7:0];
         end else if (bus_in.addr == `AGC_ADDR_AOFS_HI) begin
            rd_data_ff <= aux_offset_coefficient_ff[15:8];
         end else if (bus_in.addr == `AGC_ADDR_AGAIN_LO) begin
            rd_data_ff <= aux_gain_coefficient_ff[7:0];
         end else if (bus_in.addr == `AGC_ADDR_AGAIN_HI) begin
            rd_data_ff <= aux_gain_coefficient_ff[15:8];
         end else if (bus_in.addr == `AGC_ADDR_CTRL) begin
            rd_data_ff <= {7'h00, chop_en_ff};
         end else if (bus_in.addr == `AGC_ADDR_STATUS) begin
            rd_data_ff <= {6'h00, state_ff != agc_pkg::AGC_IDLE, conversion_ready_n_ff};
         end else begin
            rd_data_ff <= 8'h00;
         end
      end else begin
         rd_data_ff <= 8'h00;
      end
   end
endmodule

/* File: bench/agc_calibration_chk.sv */
// Purpose: Port-level checks of the calibration correction block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Idle is told apart from the store cycle by the fall of the short flag.
`timescale 1ns/100ps
module agc_calibration_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port
   input wire agc_pkg::agc_bus_s bus_in,
   input wire logic [7:0] rd_data_ff,
   // Samples, results and control
   input wire agc_pkg::agc_sample_s main_sample,
   input wire logic aux_valid,
   input wire logic main_offset_selfcal_cmd,
   input wire agc_pkg::agc_sample_s main_out_ff,
   input wire logic aux_out_valid_ff,
   input wire logic input_amplifier_short_ff,
   input wire logic conversion_ready_n_ff
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   main_lat_a: assert property (main_out_ff.valid |-> $past(main_sample.valid))
      else $error("Main result without a sample.");
   aux_lat_a: assert property (aux_valid |=> aux_out_valid_ff)
      else $error("Aux result missing.");
   cal_start_a: assert property (main_offset_selfcal_cmd && !input_amplifier_short_ff
      && !$fell(input_amplifier_short_ff) |=> input_amplifier_short_ff && conversion_ready_n_ff)
      else $error("Calibration did not start.");
   short_busy_a: assert property (input_amplifier_short_ff |-> conversion_ready_n_ff)
      else $error("Ready asserted during calibration.");
   cal_done_a: assert property ($fell(input_amplifier_short_ff) |=> !conversion_ready_n_ff)
      else $error("Ready not asserted after store.");
   cal_quiet_a: assert property (input_amplifier_short_ff[*2] |-> !main_out_ff.valid)
      else $error("Result during calibration.");
   rd_idle_a: assert property (!$past(bus_in.rd) |-> rd_data_ff == 8'h00)
      else $error("Read data outside its cycle.");
   ready_new_a: assert property (main_sample.valid && !input_amplifier_short_ff
      && !$fell(input_amplifier_short_ff) && !bus_in.rd && !main_offset_selfcal_cmd
      |=> !conversion_ready_n_ff)
      else $error("Ready not asserted after result.");
   cover property ($fell(input_amplifier_short_ff));
   cover property (main_out_ff.valid);
   cover property (aux_out_valid_ff);
endmodule
bind agc_calibration agc_calibration_chk chk_u (.ref_clk, .sys_rst, .bus_in, .rd_data_ff,
   .main_sample, .aux_valid, .main_offset_selfcal_cmd, .main_out_ff, .aux_out_valid_ff,
   .input_amplifier_short_ff, .conversion_ready_n_ff);

/* File: bench/agc_host.sv */
// Purpose: Host controller model driving the register port and command.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Released address and data are inverted so stale values never look valid.
`timescale 1ns/100ps
module agc_host (
   // Clock
   input wire logic ref_clk,
   // Register port and command
   output agc_pkg::agc_bus_s bus_in,
   output logic cmd,
   input wire logic [7:0] rd_data_ff
);
   // Host-side copy of the input selector; the command is only sent with all inputs open.
   logic [7:0] main_input_selector;
   initial begin
      bus_in = '0;
      cmd = 1'b0;
      main_input_selector = 8'h00;
   end
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      bus_in <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_in <= '{~a, ~d, 1'b0, 1'b0};
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      bus_in <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_in <= '{~a, 8'hff, 1'b0, 1'b0};
      @(posedge ref_clk);
      d = rd_data_ff;
   endtask
   // Only offset calibration is ever requested, so no gain step can precede it.
   task automatic cal;
      @(posedge ref_clk);
      main_input_selector <= 8'hff;
      @(posedge ref_clk);
      if (main_input_selector == 8'hff) begin
         cmd <= 1'b1;
      end
      @(posedge ref_clk);
      cmd <= 1'b0;
   endtask
   task automatic reselect(logic [7:0] ch);
      @(posedge ref_clk);
      main_input_selector <= ch;
   endtask
endmodule

/* File: bench/adc_gain_offset_calibration_test.sv */
// Purpose: Self-checking bench for the calibration correction block.
// Assumes: Integer reference model with floor division and saturation.
// Notes: Aux offsets stay positive since their sign handling is open.
`timescale 1ns/100ps
`include "agc_defines.svh"
module adc_gain_offset_calibration_test;
   logic ref_clk, sys_rst, aux_valid, aux_out_valid_ff, short_ff, rdy_n, cmd;
   logic [23:0] aux_sample, aux_out_ff;
   logic [7:0] rd_data_ff, rb;
   agc_pkg::agc_bus_s bus_in;
   agc_pkg::agc_sample_s main_sample, main_out_ff;
   logic [7:0] addr_t [10] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
      8'h17, 8'h18, 8'h19, 8'h1a};
   logic [7:0] rst_t [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40,
      8'h00, 8'h00, 8'h00, 8'h40};
   int err_count = 0;
   int checks = 0;
   longint ofs, gain, aofs, again, chop, sum, d, e;
   agc_calibration dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_in(bus_in),
      .rd_data_ff(rd_data_ff), .main_sample(main_sample), .aux_sample(aux_sample),
      .aux_valid(aux_valid), .main_offset_selfcal_cmd(cmd), .main_out_ff(main_out_ff),
      .aux_out_ff(aux_out_ff), .aux_out_valid_ff(aux_out_valid_ff),
      .input_amplifier_short_ff(short_ff), .conversion_ready_n_ff(rdy_n));
   agc_host host_u (.ref_clk(ref_clk), .bus_in(bus_in), .cmd(cmd), .rd_data_ff(rd_data_ff));
   task automatic chk(bit ok, logic [31:0] g, logic [31:0] x);
      checks++;
      if (!ok) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic cmp_reg(logic [7:0] g, logic [7:0] x);
      chk(g === x, 32'(g), 32'(x));
   endtask
   task automatic cmp_main(logic [31:0] g, logic [31:0] x);
      chk(g === x, g, x);
   endtask
   task automatic cmp_aux(logic [23:0] g, logic [23:0] x);
      chk(g === x, 32'(g), 32'(x));
   endtask
   task automatic cmp_flag(logic g, logic x);
      chk(g === x, 32'(g), 32'(x));
   endtask
   function automatic longint sat(longint v, int w);
      longint hi;
      hi = (longint'(1) <<< (w - 1)) - 1;
      return v > hi ? hi : (v < -hi - 1 ? -hi - 1 : v);
   endfunction
   task automatic give_verdict;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      #50000;
      err_count++;
      give_verdict;
   end
   initial begin
      sys_rst = 1'b1;
      main_sample = '0;
      aux_sample = '0;
      aux_valid = 1'b0;
      void'($urandom(46156));
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         host_u.rd(addr_t[i], rb);
         cmp_reg(rb, rst_t[i]);
      end
      $display("test reset_values done");
      for (int n = 0; n < 24; n++) begin
         ofs = n == 0 ? 'h7f_ffff : (n == 1 ? -'h80_0000 : (n == 2 ? 0 : $signed(24'($urandom))));
         // The mixed-sign choice above is unsigned, so the sign is put back from bit 23.
         ofs = longint'($signed(24'(ofs)));
         gain = n == 2 ? 'h40_0000 : (n < 5 ? 'hff_ffff : $urandom_range('h60_0000, 'h20_0000));
         aofs = $urandom_range('h7fff, 0);
         again = $urandom_range('h6000, 'h2000);
         chop = n % 3 == 2;
         for (int b = 0; b < 3; b++) begin
            host_u.wr(8'h07 + 8'(b), 8'(ofs >> 8 * b));
            host_u.wr(8'h0a + 8'(b), 8'(gain >> 8 * b));
         end
         for (int b = 0; b < 2; b++) begin
            host_u.wr(8'h17 + 8'(b), 8'(aofs >> 8 * b));
            host_u.wr(8'h19 + 8'(b), 8'(again >> 8 * b));
         end
         host_u.wr(`AGC_ADDR_CTRL, 8'(chop));
         host_u.rd(8'h0c, rb);
         cmp_reg(rb, 8'(gain >> 16));
         host_u.rd(8'h30, rb);
         cmp_reg(rb, 8'h00);
         host_u.rd(`AGC_ADDR_CTRL, rb);
         cmp_reg(rb, 8'(chop));
         d = n == 3 ? 'h7fff_ffff : (n == 4 ? -'h8000_0000 : $signed($urandom));
         d = longint'($signed(32'(d)));
         main_sample <= '{1'b1, 32'(d)};
         aux_sample <= 24'($urandom);
         aux_valid <= 1'b1;
         @(posedge ref_clk);
         main_sample.valid <= 1'b0;
         aux_valid <= 1'b0;
         @(posedge ref_clk);
         cmp_flag(main_out_ff.valid, 1'b1);
         cmp_flag(aux_out_valid_ff, 1'b1);
         e = sat(((d - (chop ? 0 : ofs * 256)) * gain) >>> 22, 32);
         cmp_main(main_out_ff.data, 32'(e));
         e = sat(((longint'($signed(aux_sample)) - aofs * 256) * again) >>> 14, 24);
         cmp_aux(aux_out_ff, 24'(e));
      end
      $display("test correction done");
      host_u.wr(`AGC_ADDR_CTRL, 8'h00);
      host_u.cal();
      @(posedge ref_clk);
      cmp_flag(short_ff, 1'b1);
      cmp_flag(rdy_n, 1'b1);
      host_u.rd(`AGC_ADDR_STATUS, rb);
      cmp_reg(rb, 8'h03);
      sum = 0;
      for (int i = 0; i < 16; i++) begin
         d = longint'($urandom_range('h20_0000, 0)) - 'h10_0000;
         sum += d;
         main_sample <= '{1'b1, 32'(d)};
         @(posedge ref_clk);
         main_sample.valid <= 1'b0;
         @(posedge ref_clk);
      end
      for (int w = 0; w < 10 && rdy_n !== 1'b0; w++) @(posedge ref_clk);
      cmp_flag(rdy_n, 1'b0);
      host_u.reselect(8'h01);
      e = sum >>> 12;
      for (int b = 0; b < 3; b++) begin
         host_u.rd(8'h07 + 8'(b), rb);
         cmp_reg(rb, 8'(e >> 8 * b));
      end
      $display("test self_calibration done");
      give_verdict;
   end
endmodule
